// >>> design/light_link_host.sv
`timescale 1ns/1ns
`default_nettype none
module light_link_host #(
  parameter int QUARTER = light_link_pkg::SCL_QUARTER_CYC  // cycles per quarter bit
) (
  input  wire logic        clock_in,        // system clock
  input  wire logic        srst_in,         // sync reset, high
  input  wire logic [4:0]  address_in,      // avalon byte address
  input  wire logic        read_in,         // avalon read
  input  wire logic        write_in,        // avalon write
  input  wire logic [31:0] writedata_in,    // avalon write data
  output logic      [31:0] readdata_out,    // avalon read data
  output logic             waitrequest_out, // avalon wait
  light_link_if.host       link             // two-wire bus
);
  import light_link_pkg::*;

  // bus item sequences per operation
  localparam item_s I_S   = '{K_START, B_AW};
  localparam item_s I_P   = '{K_STOP, B_AW};
  localparam item_s I_E   = '{K_END, B_AW};
  localparam item_s I_AW  = '{K_TX, B_AW};
  localparam item_s I_AR  = '{K_TX, B_AR};
  localparam item_s I_CD  = '{K_TX, B_CODE};
  localparam item_s I_D0  = '{K_TX, B_D0};
  localparam item_s I_D1  = '{K_TX, B_D1};
  localparam item_s I_ARA = '{K_TX, B_ARA};
  localparam item_s I_RX  = '{K_RX, B_AW};
  localparam item_s I_RXL = '{K_RXL, B_AW};

  function automatic item_seq_t seq_of(input host_op_e o);
    unique case (o)
      OP_SEND:  seq_of = {I_E, I_E, I_E, I_E, I_P, I_CD, I_AW, I_S};
      OP_WBYTE: seq_of = {I_E, I_E, I_E, I_P, I_D0, I_CD, I_AW, I_S};
      OP_WWORD: seq_of = {I_E, I_E, I_P, I_D1, I_D0, I_CD, I_AW, I_S};
      OP_RBYTE: seq_of = {I_E, I_P, I_RXL, I_AR, I_S, I_CD, I_AW, I_S};
      // one transfer returns both bytes
      OP_RWORD: seq_of = {I_P, I_RXL, I_RX, I_AR, I_S, I_CD, I_AW, I_S};
      // alert response read clears the alert
      OP_ARA:   seq_of = {I_E, I_E, I_E, I_E, I_P, I_RXL, I_ARA, I_S};
      default:  seq_of = {I_E, I_E, I_E, I_E, I_E, I_E, I_E, I_E};
    endcase
  endfunction

  logic        sda_m, sda_s, alt_m, alt_s; // pin synchronisers
  logic        served;                     // avalon answer cycle
  logic [6:0]  slave_addr;                 // target address
  logic [7:0]  code;                       // command byte
  logic [15:0] wdata;                      // data to write
  logic [15:0] rdata;                      // data read back
  host_op_e    op;                         // running operation
  logic        busy, nack, aborting, rx_hi; // engine flags
  logic [2:0]  step;                       // item index
  logic [1:0]  q;                          // quarter of bit
  logic [15:0] qcnt;                       // quarter timer
  logic [3:0]  bitn;                       // bit within byte
  logic [7:0]  rx_shift;                   // incoming byte
  logic        scl_q, sda_low_q;           // registered pins

  // two-flop sync of bus inputs
  always_ff @(posedge clock_in) begin
    sda_m <= link.sda_line;
    sda_s <= sda_m;
    alt_m <= link.alert_line;
    alt_s <= alt_m;
  end

  // avalon decode, start request held off while busy
  wire req       = read_in || write_in;
  wire sel_ctrl  = address_in == HOST_REG_CTRL;
  wire go_hold   = write_in && sel_ctrl && busy;
  wire wr_take   = write_in && !waitrequest_out;
  assign waitrequest_out = req && !served;
  wire [31:0] next_readdata =
      (address_in == HOST_REG_ADDR)  ? {25'h0000000, slave_addr} :
      (address_in == HOST_REG_CODE)  ? {24'h000000, code} :
      (address_in == HOST_REG_WDATA) ? {16'h0000, wdata} :
      (address_in == HOST_REG_RDATA) ? {16'h0000, rdata} :
      sel_ctrl ? {29'h00000000, !alt_s, nack, busy} : 32'h00000000;

  // one wait cycle per access, a start write while busy waits until idle
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      served       <= 1'b0;
      readdata_out <= 32'h00000000;
    end else begin
      served <= req && !served && !go_hold;
      if (req && !served) readdata_out <= next_readdata;
    end
  end

  // current item and its byte
  item_seq_t  seq;
  assign seq = seq_of(op);
  wire item_kind_e kind = aborting ? K_STOP : seq[step].kind;
  wire byte_sel_e  sel  = seq[step].sel;
  wire is_bit  = (kind == K_TX) || (kind == K_RX) || (kind == K_RXL);
  wire tick    = qcnt == 16'(QUARTER - 1);
  wire [7:0] tx_byte =
      (sel == B_AW)   ? {slave_addr, 1'b0} :
      (sel == B_AR)   ? {slave_addr, 1'b1} :
      (sel == B_CODE) ? code :
      (sel == B_D0)   ? wdata[7:0] :
      (sel == B_D1)   ? wdata[15:8] : {ALERT_RESP_ADDR, 1'b1};
  wire next_scl = !busy ? 1'b1 :
      (kind == K_STOP) ? (q != 2'd0) :
      (kind == K_START || is_bit) ? (q == 2'd1 || q == 2'd2) : 1'b1;
  wire next_sda_low = !busy ? 1'b0 :
      (kind == K_START) ? (q >= 2'd2) :
      (kind == K_STOP)  ? (q <= 2'd1) :
      (kind == K_TX)    ? (bitn < 4'd8 && !tx_byte[~bitn[2:0]]) :
      (kind == K_RX)    ? (bitn == 4'd8) : 1'b0;

  // host registers and bus engine
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      slave_addr <= 7'h00; code <= 8'h00; wdata <= 16'h0000; rdata <= 16'h0000;
      op <= OP_SEND; busy <= 1'b0; nack <= 1'b0; aborting <= 1'b0; rx_hi <= 1'b0;
      step <= 3'd0; q <= 2'd0; qcnt <= 16'h0000; bitn <= 4'h0; rx_shift <= 8'h00;
    end else if (wr_take && sel_ctrl) begin
      op <= host_op_e'(writedata_in[2:0]);
      busy <= 1'b1; nack <= 1'b0; aborting <= 1'b0; rx_hi <= 1'b0;
      step <= 3'd0; q <= 2'd0; qcnt <= 16'h0000; bitn <= 4'h0;
    end else if (wr_take) begin
      if (address_in == HOST_REG_ADDR)  slave_addr <= writedata_in[6:0];
      if (address_in == HOST_REG_CODE)  code <= writedata_in[7:0];
      if (address_in == HOST_REG_WDATA) wdata <= writedata_in[15:0];
    end else if (busy) begin
      if (kind == K_END) begin
        busy <= 1'b0;
      end else if (!tick) begin
        qcnt <= qcnt + 16'h0001;
      end else begin
        qcnt <= 16'h0000;
        q    <= q + 2'd1;
        if (q == 2'd2 && is_bit) begin
          if (bitn < 4'd8) rx_shift <= {rx_shift[6:0], sda_s};
          else if (kind == K_TX && sda_s) nack <= 1'b1;
        end
        if (q == 2'd3) begin
          if (!is_bit) begin
            // last slot done or abort: stop instead of wrapping to slot 0
            if (aborting || step == 3'd7) busy <= 1'b0;
            else step <= step + 3'd1;
          end else if (bitn != 4'd8) begin
            bitn <= bitn + 4'h1;
          end else begin
            bitn <= 4'h0;
            step <= step + 3'd1;
            if (kind == K_TX) aborting <= nack;
            if (kind != K_TX && rx_hi) rdata[15:8] <= rx_shift;
            if (kind != K_TX && !rx_hi) rdata[7:0] <= rx_shift;
            if (kind != K_TX) rx_hi <= 1'b1;
          end
        end
      end
    end
  end

  // registered bus pins
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      scl_q     <= 1'b1;
      sda_low_q <= 1'b0;
    end else begin
      scl_q     <= next_scl;
      sda_low_q <= next_sda_low;
    end
  end
  assign link.scl          = scl_q;
  assign link.sda_host_oe  = sda_low_q;
  assign link.sda_host_out = 1'b0;
endmodule
`default_nettype wire

// >>> design/light_sensor_dev.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - persist zero: interrupt every conversion
// - persist one: single out-of-window result interrupts
// - persist N: N consecutive out-of-window results
// - level style follows window and persistence
// - level interrupt low until command clear
// - host clears alert via response address read
// - alert response returns own address, upper bits
// - lost arbitration leaves interrupt pending
// - style 11 sets interrupt, acts as alert
// - only channel 0 feeds the interrupt
// - style field bits 5:4 selects output style
// - persistence bits 3:0, reserved 7:6 zero
// - identification register constant, read only
// - result bytes read only, reset zero
// - results at addresses C, D, E, F
// - low byte read shadows the high byte
// - host reads low byte before high
// - word read returns both result bytes
// - clear bit clears pending, self clearing
// - outside: at or below low, above high
module light_sensor_dev #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A,  // bus address
  parameter logic [3:0] PART_CODE  = 4'h5,   // arbitrary value
  parameter logic [3:0] REV_CODE   = 4'h1    // arbitrary value
) (
  input  wire logic        clock_in,        // system clock
  input  wire logic        srst_in,         // sync reset, high
  light_link_if.dev        link,            // two-wire bus
  input  wire logic        conv_done_in,    // conversion finished pulse
  input  wire logic [15:0] ch0_in,          // channel 0 result
  input  wire logic [15:0] ch1_in,          // channel 1 result
  input  wire logic [15:0] low_limit_in,    // low threshold
  input  wire logic [15:0] high_limit_in,   // high threshold
  output logic             irq_pending_out, // pending interrupt
  output logic      [7:0]  int_ctrl_out     // interrupt control copy
);
  import light_link_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} slave_state_e;

  slave_state_e state;          // bus slave state
  logic        scl_m, scl_s, scl_d; // clock sync and history
  logic        sda_m, sda_s, sda_d; // data sync and history
  logic [7:0]  shift;           // incoming byte
  logic [7:0]  tx_shift;        // outgoing byte
  logic [3:0]  bitcnt;          // bits in this byte
  logic        drive_low;       // pull data low
  logic        rw;              // read transfer
  logic        ara;             // alert response transfer
  logic        lost;            // arbitration lost
  logic        first_wr;        // next write byte is command
  logic [3:0]  reg_ptr;         // pointer from command byte
  logic [3:0]  cur_ptr;         // pointer within transfer
  logic        word_mode;       // word protocol
  logic [7:0]  int_ctrl;        // interrupt control
  logic [15:0] res0, res1;      // conversion results
  logic [7:0]  shadow0, shadow1; // high byte shadows
  logic [3:0]  persist_cnt;     // out-of-window run
  logic        pending;         // interrupt pending

  // two-flop sync, third stage for edges
  always_ff @(posedge clock_in) begin
    scl_m <= link.scl;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= link.sda_line;
    sda_s <= sda_m;
    sda_d <= sda_s;
  end

  // bus conditions
  wire start_seen = scl_s && scl_d && sda_d && !sda_s;
  wire stop_seen  = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise   = scl_s && !scl_d;
  wire scl_fall   = !scl_s && scl_d;

  // control fields
  wire [3:0]       persist = int_ctrl[PERSIST_MSB:0];
  wire irq_style_e style   = irq_style_e'(int_ctrl[STYLE_MSB:STYLE_LSB]);
  wire alert_style = (style == STYLE_ALERT) || (style == STYLE_TEST);

  // address phase decisions
  wire addr_hit = shift[7:1] == SLAVE_ADDR;
  wire ara_hit  = (shift[7:1] == ALERT_RESP_ADDR) && shift[0] && pending && alert_style;
  wire addr_end = scl_fall && (state == ST_ADDR) && (bitcnt == 4'd8);

  // write byte handling
  wire byte_done_wr = scl_fall && (state == ST_WR) && (bitcnt == 4'd8);
  wire cmd_byte     = byte_done_wr && first_wr && shift[CMD_SEL_BIT];
  wire clear_req    = cmd_byte && shift[CMD_CLEAR_BIT];
  wire ctrl_write   = byte_done_wr && !first_wr && (cur_ptr == REG_INT_CTRL);
  wire test_req     = ctrl_write && (shift[STYLE_MSB:STYLE_LSB] == 2'b11);

  // read byte handling
  wire rd_done   = scl_fall && (state == ST_RD) && (bitcnt == 4'd8);
  wire ara_clear = rd_done && ara && !lost;

  // register read selection
  wire [7:0] rd_byte =
      ara ? {SLAVE_ADDR, 1'b0} :
      (cur_ptr == REG_INT_CTRL) ? {2'b00, int_ctrl[5:0]} :
      (cur_ptr == REG_ID)       ? {PART_CODE, REV_CODE} :
      (cur_ptr == REG_CH0_LO)   ? res0[7:0] :
      (cur_ptr == REG_CH0_HI)   ? shadow0 :
      (cur_ptr == REG_CH1_LO)   ? res1[7:0] :
      (cur_ptr == REG_CH1_HI)   ? shadow1 : READ_NONE;

  // window and persistence on channel 0 only
  wire out_win = (ch0_in <= low_limit_in) || (ch0_in > high_limit_in);
  wire [3:0] run_inc = (persist_cnt == 4'hF) ? 4'hF : persist_cnt + 4'h1;
  wire fire = conv_done_in && ((persist == 4'h0) ||
                               (out_win && (run_inc >= persist)));
  wire set_irq = (fire && (style != STYLE_OFF)) || test_req;
  wire clr_irq = clear_req || (ara_clear && alert_style);
  wire next_pending = set_irq || (pending && !clr_irq);

  // results and interrupt state
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      res0        <= RESULT_RESET;
      res1        <= RESULT_RESET;
      persist_cnt <= 4'h0;
      pending     <= 1'b0;
    end else begin
      if (conv_done_in) begin
        res0        <= ch0_in;
        res1        <= ch1_in;
        persist_cnt <= out_win ? run_inc : 4'h0;
      end
      pending <= next_pending;
    end
  end

  // bus slave
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= ST_IDLE; shift <= 8'h00; tx_shift <= 8'h00; bitcnt <= 4'h0;
      drive_low <= 1'b0; rw <= 1'b0; ara <= 1'b0; lost <= 1'b0; first_wr <= 1'b0;
      reg_ptr <= 4'h0; cur_ptr <= 4'h0; word_mode <= 1'b0;
      int_ctrl <= INT_CTRL_RESET;
      shadow0 <= 8'h00; shadow1 <= 8'h00;
    end else if (start_seen) begin
      // new transfer, also repeated start
      state <= ST_ADDR; bitcnt <= 4'h0; drive_low <= 1'b0; lost <= 1'b0; first_wr <= 1'b1;
    end else if (stop_seen) begin
      state <= ST_IDLE; drive_low <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        ST_ADDR, ST_WR: begin
          shift  <= {shift[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
        ST_RD: begin
          // released one but line low: lost
          if (ara && !drive_low && !sda_s) lost <= 1'b1;
          bitcnt <= bitcnt + 4'h1;
        end
        ST_RD_ACK: begin
          if (sda_s) state <= ST_IDLE; // host nack ends read
        end
        ST_IDLE, ST_ADDR_ACK, ST_WR_ACK: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        ST_ADDR: begin
          if (addr_end && (addr_hit || ara_hit)) begin
            state <= ST_ADDR_ACK; drive_low <= 1'b1;
            rw <= shift[0]; ara <= ara_hit && !addr_hit; cur_ptr <= reg_ptr;
          end else if (addr_end) begin
            state <= ST_IDLE; // not ours
          end
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          if (rw) begin
            // first bit of next read byte
            state <= ST_RD; bitcnt <= 4'h0;
            drive_low <= !rd_byte[7];
            tx_shift  <= {rd_byte[6:0], 1'b0};
            if (!ara && cur_ptr == REG_CH0_LO) shadow0 <= res0[15:8];
            if (!ara && cur_ptr == REG_CH1_LO) shadow1 <= res1[15:8];
          end else begin
            state <= ST_WR; bitcnt <= 4'h0; drive_low <= 1'b0;
          end
        end
        ST_WR: begin
          if (byte_done_wr) begin
            state <= ST_WR_ACK; drive_low <= 1'b1; first_wr <= 1'b0;
            if (cmd_byte) begin
              reg_ptr   <= shift[3:0];
              cur_ptr   <= shift[3:0];
              word_mode <= shift[CMD_WORD_BIT];
            end
            if (ctrl_write) int_ctrl <= {2'b00, shift[5:0]};
            if (!first_wr) cur_ptr <= cur_ptr + {3'b000, word_mode};
          end
        end
        ST_WR_ACK: begin
          state <= ST_WR; bitcnt <= 4'h0; drive_low <= 1'b0;
        end
        ST_RD: begin
          if (rd_done) begin
            // release for host ack, step word pointer
            state <= ST_RD_ACK; drive_low <= 1'b0;
            cur_ptr <= cur_ptr + {3'b000, word_mode};
          end else begin
            drive_low <= !lost && !tx_shift[7];
            tx_shift  <= {tx_shift[6:0], 1'b0};
          end
        end
        ST_IDLE: begin
        end
      endcase
    end
  end

  // pins: open drain, alert released while style is off
  assign link.sda_dev_oe  = drive_low;
  assign link.sda_dev_out = 1'b0;
  assign link.alert_oe    = pending && (style != STYLE_OFF);
  assign link.alert_out   = 1'b0;
  assign irq_pending_out  = pending;
  assign int_ctrl_out     = int_ctrl;
endmodule
`default_nettype wire

// >>> include/light_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface light_link_if;
  logic scl;           // bus clock from host
  logic sda_host_out;  // host data level
  logic sda_host_oe;   // host pulls data low
  logic sda_dev_out;   // device data level
  logic sda_dev_oe;    // device pulls data low
  logic alert_out;     // device alert level
  logic alert_oe;      // device pulls alert low
  logic sda_line;      // resolved open-drain data
  logic alert_line;    // resolved open-drain alert, low active
  // wired-and with pull-ups
  assign sda_line   = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
  assign alert_line = !(alert_oe && !alert_out);
  modport host (output scl, sda_host_out, sda_host_oe, input sda_line, alert_line);
  modport dev  (input scl, sda_line, output sda_dev_out, sda_dev_oe, alert_out, alert_oe);
endinterface
`default_nettype wire

// >>> include/light_link_pkg.sv
package light_link_pkg;
  // device register pointers
  localparam logic [3:0] REG_INT_CTRL = 4'h6;     // interrupt control
  localparam logic [3:0] REG_ID       = 4'hA;     // identification
  localparam logic [3:0] REG_CH0_LO   = 4'hC;     // channel 0 low byte
  localparam logic [3:0] REG_CH0_HI   = 4'hD;     // channel 0 high byte
  localparam logic [3:0] REG_CH1_LO   = 4'hE;     // channel 1 low byte
  localparam logic [3:0] REG_CH1_HI   = 4'hF;     // channel 1 high byte
  // command byte fields
  localparam int CMD_SEL_BIT   = 7;               // marks a command byte
  localparam int CMD_CLEAR_BIT = 6;               // interrupt clear, self clearing
  localparam int CMD_WORD_BIT  = 5;               // word protocol
  // interrupt control fields
  localparam int STYLE_MSB     = 5;               // style field top
  localparam int STYLE_LSB     = 4;               // style field bottom
  localparam int PERSIST_MSB   = 3;               // persistence field top
  localparam logic [7:0]  INT_CTRL_RESET = 8'h00; // control after reset
  localparam logic [15:0] RESULT_RESET   = 16'h0000; // results after reset
  localparam logic [7:0]  READ_NONE      = 8'h00; // unmapped read value
  localparam logic [6:0]  ALERT_RESP_ADDR = 7'h0C; // alert response address
  typedef enum logic [1:0] {STYLE_OFF, STYLE_LEVEL, STYLE_ALERT, STYLE_TEST} irq_style_e;
  // host register byte offsets
  localparam logic [4:0] HOST_REG_ADDR  = 5'h00;  // slave address
  localparam logic [4:0] HOST_REG_CODE  = 5'h04;  // command byte
  localparam logic [4:0] HOST_REG_WDATA = 5'h08;  // write data word
  localparam logic [4:0] HOST_REG_CTRL  = 5'h0C;  // start / status
  localparam logic [4:0] HOST_REG_RDATA = 5'h10;  // read data word
  typedef enum logic [2:0] {OP_SEND, OP_WBYTE, OP_WWORD, OP_RBYTE, OP_RWORD, OP_ARA} host_op_e;
  typedef enum logic [2:0] {K_START, K_TX, K_RX, K_RXL, K_STOP, K_END} item_kind_e;
  typedef enum logic [2:0] {B_AW, B_AR, B_CODE, B_D0, B_D1, B_ARA} byte_sel_e;
  typedef struct packed {
    item_kind_e kind;                             // what the item does
    byte_sel_e  sel;                              // byte sent by a tx item
  } item_s;
  typedef item_s [7:0] item_seq_t;
  // bus timing
  localparam int CLK_PERIOD_NS   = 20;            // system clock period
  localparam int SCL_PERIOD_NS   = 10000;         // bus clock period
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage

// >>> verif/light_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module light_link_chk (
  input  wire logic        clock_in,        // system clock
  input  wire logic        srst_in,         // sync reset
  input  wire logic        scl,             // bus clock
  input  wire logic        alert_line,      // resolved alert
  input  wire logic        alert_oe,        // device alert drive
  input  wire logic        irq_pending_out, // pending interrupt
  input  wire logic [7:0]  int_ctrl_out,    // control copy
  input  wire logic        conv_done_in,    // conversion pulse
  input  wire logic [15:0] ch0_in,          // channel 0 result
  input  wire logic [15:0] low_limit_in,    // low threshold
  input  wire logic [15:0] high_limit_in    // high threshold
);
  logic [5:0] hi_cnt;                        // cycles of bus clock high
  wire  logic [1:0] style;                   // style field
  assign style = int_ctrl_out[5:4];
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // how long the bus clock has rested high, long rest means no transfer
  always_ff @(posedge clock_in) begin
    if (srst_in || !scl) hi_cnt <= 6'h00;
    else if (hi_cnt != 6'h3F) hi_cnt <= hi_cnt + 6'h01;
  end
  // conversion landing outside the window
  sequence s_out_win;
    conv_done_in && (ch0_in <= low_limit_in || ch0_in > high_limit_in);
  endsequence
  // pending shows up shortly
  sequence s_pend_soon;
    ##[0:40] irq_pending_out;
  endsequence
  chk_alert_drive: assert property (alert_oe == (irq_pending_out && style != 2'b00))
    else $error("alert drive does not follow pending and style");
  chk_off_released: assert property (style == 2'b00 |-> alert_line)
    else $error("alert line low while output disabled");
  chk_persist_zero: assert property (conv_done_in && int_ctrl_out[3:0] == 4'h0 && style != 2'b00 |=> irq_pending_out)
    else $error("no interrupt after conversion with zero persistence");
  chk_persist_one: assert property (s_out_win ##0 (int_ctrl_out[3:0] == 4'h1 && style != 2'b00) |=> irq_pending_out)
    else $error("no interrupt after single outside result");
  chk_rise_cause: assert property ($rose(irq_pending_out) |-> $past(conv_done_in) || style == 2'b11)
    else $error("interrupt raised without a conversion");
  chk_test_sets: assert property ($rose(style == 2'b11) |-> s_pend_soon)
    else $error("test style did not raise interrupt");
  chk_clear_on_bus: assert property ($fell(irq_pending_out) |-> hi_cnt < 6'd20)
    else $error("interrupt cleared outside a transfer");
  chk_reserved_zero: assert property (int_ctrl_out[7:6] == 2'b00)
    else $error("reserved control bits not zero");
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import light_link_pkg::*;
  localparam logic [6:0] DEV  = 7'h2A;  // bus address, arbitrary value
  localparam logic [3:0] PART = 4'h6;   // arbitrary value
  localparam logic [3:0] REV  = 4'h3;   // arbitrary value
  logic        clock_in, srst_in, read_in, write_in, conv_done_in; // bench drives
  logic        waitrequest_out, irq_pending_out;                   // design flags
  logic [4:0]  address_in;                                         // avalon address
  logic [7:0]  int_ctrl_out;                                       // control copy
  logic [15:0] ch0_in, ch1_in, low_limit_in, high_limit_in;        // conversion inputs
  logic [31:0] writedata_in, readdata_out, q;                      // avalon data
  logic [15:0] pv [6] = '{16'h0400, 16'h0100, 16'h0400, 16'h0801, 16'h0801, 16'h0801}; // run pattern
  int          miscompares, n_checks;                              // counters
  light_link_if lnk ();                                            // two-wire bus
  light_link_host #(.QUARTER(4)) u_light_link_host (.clock_in, .srst_in, .address_in, .read_in, .write_in,
    .writedata_in, .readdata_out, .waitrequest_out, .link(lnk.host));
  light_sensor_dev #(.SLAVE_ADDR(DEV), .PART_CODE(PART), .REV_CODE(REV)) u_light_sensor_dev (.clock_in, .srst_in,
    .link(lnk.dev), .conv_done_in, .ch0_in, .ch1_in, .low_limit_in, .high_limit_in, .irq_pending_out, .int_ctrl_out);
  light_link_chk u_light_link_chk (.clock_in, .srst_in, .scl(lnk.scl), .alert_line(lnk.alert_line),
    .alert_oe(lnk.alert_oe), .irq_pending_out, .int_ctrl_out, .conv_done_in, .ch0_in, .low_limit_in, .high_limit_in);
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // value compare
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // flag compare
  task automatic cmp_flag(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask
  // one avalon access, held until waitrequest low
  task automatic av(input logic [4:0] a, input logic wr, input logic [31:0] d);
    address_in <= a;
    write_in <= wr;
    read_in <= !wr;
    writedata_in <= d;
    @(posedge clock_in);
    while (waitrequest_out) @(posedge clock_in);
    q = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clock_in);
  endtask
  // one bus transaction, waits for idle, leaves read data in q
  task automatic bus(input logic [2:0] op, input logic [7:0] code, input logic [15:0] d);
    av(HOST_REG_ADDR, 1'b1, {25'h0, DEV});
    av(HOST_REG_CODE, 1'b1, {24'h0, code});
    av(HOST_REG_WDATA, 1'b1, {16'h0, d});
    av(HOST_REG_CTRL, 1'b1, {29'h0, op});
    q = 32'h1;
    while (q[0]) av(HOST_REG_CTRL, 1'b0, 32'h0);
    av(HOST_REG_RDATA, 1'b0, 32'h0);
  endtask
  // one conversion pulse
  task automatic conv(input logic [15:0] c0, input logic [15:0] c1);
    ch0_in <= c0;
    ch1_in <= c1;
    conv_done_in <= 1'b1;
    @(posedge clock_in);
    conv_done_in <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask
  // clock
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge clock_in);
    miscompares++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {read_in, write_in, conv_done_in, address_in, writedata_in, ch0_in, ch1_in} = '0;
    low_limit_in = 16'h0100;
    high_limit_in = 16'h0800;
    srst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    bus(3'd3, 8'h8A, 16'h0);
    cmp({8'h00, q[7:0]}, {8'h00, PART, REV});
    bus(3'd4, 8'hAC, 16'h0);
    cmp(q[15:0], RESULT_RESET);
    bus(3'd3, 8'h86, 16'h0);
    cmp({8'h00, q[7:0]}, {8'h00, INT_CTRL_RESET});
    av(5'h14, 1'b0, 32'h0);
    cmp(q[15:0], 16'h0000);
    $display("test 1 done");
    conv(16'h1234, 16'h5678);
    bus(3'd3, 8'h8C, 16'h0);
    cmp({8'h00, q[7:0]}, 16'h0034);
    conv(16'hABCD, 16'h5678);
    bus(3'd3, 8'h8D, 16'h0);
    cmp({8'h00, q[7:0]}, 16'h0012);
    bus(3'd4, 8'hAE, 16'h0);
    cmp(q[15:0], 16'h5678);
    bus(3'd4, 8'hAC, 16'h0);
    cmp(q[15:0], 16'hABCD);
    cmp_flag(irq_pending_out, 1'b0);
    cmp_flag(lnk.alert_line, 1'b1);
    $display("test 2 done");
    bus(3'd1, 8'h86, 16'h0013);
    bus(3'd3, 8'h86, 16'h0);
    cmp({8'h00, q[7:0]}, 16'h0013);
    bus(3'd0, 8'hC6, 16'h0);
    cmp_flag(irq_pending_out, 1'b0);
    for (int i = 0; i < 6; i++) begin
      conv(pv[i], 16'hFFFF);
      cmp_flag(irq_pending_out, i == 5);
    end
    cmp_flag(lnk.alert_line, 1'b0);
    $display("test 3 done");
    bus(3'd1, 8'h86, 16'h0010);
    bus(3'd0, 8'hC6, 16'h0);
    conv(16'h0400, 16'h0000);
    cmp_flag(irq_pending_out, 1'b1);
    bus(3'd0, 8'hC6, 16'h0);
    cmp_flag(irq_pending_out, 1'b0);
    bus(3'd1, 8'h86, 16'h0021);
    conv(16'h0801, 16'h0000);
    cmp_flag(irq_pending_out, 1'b1);
    bus(3'd5, 8'h00, 16'h0);
    cmp({8'h00, q[7:0]}, {8'h00, DEV, 1'b0});
    cmp_flag(irq_pending_out, 1'b0);
    $display("test 4 done");
    bus(3'd1, 8'h86, 16'h0030);
    cmp_flag(irq_pending_out, 1'b1);
    bus(3'd5, 8'h00, 16'h0);
    cmp({8'h00, q[7:0]}, {8'h00, DEV, 1'b0});
    cmp_flag(irq_pending_out, 1'b0);
    $display("test 5 done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
